// *** hdl/tcp_link_if.sv ***
// interface: carrier between the tick counter control and its prescaler and pin sampler
`timescale 1ns/100ps
`default_nettype none

interface tcp_link_if;
  logic       tick;
  logic       clr;
  logic [2:0] rate;
  logic       pulse;
  logic       pin;
  logic       fall_sel;
  logic       edge_seen;

  // ==========================================================
  // one modport per party
  modport ctrl  (output tick, clr, rate, pin, fall_sel, input pulse, edge_seen);
  modport presc (input tick, clr, rate, output pulse);
  modport smp   (input pin, fall_sel, output edge_seen);
endinterface

`default_nettype wire

// *** hdl/tcp_pin_sampler.sv ***
// module: samples the external count pin and flags the selected transition
`timescale 1ns/100ps
`default_nettype none

module tcp_pin_sampler (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // link to control
  tcp_link_if.smp lk
);

  logic prev_q;
  logic edge_q;

  // ==========================================================
  // one sample per oscillator edge, the pin is taken as synchronous
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      prev_q <= lk.pin;
      edge_q <= lk.fall_sel ? (prev_q & ~lk.pin) : (~prev_q & lk.pin);
    end
  end

  assign lk.edge_seen = edge_q;

  a_edge_select: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (lk.fall_sel && prev_q && !lk.pin) |=> lk.edge_seen) else $error("falling edge lost");

endmodule

`default_nettype wire

// *** hdl/tcp_pkg.sv ***
// package: register map, field positions and reset values of the tick counter block
package tcp_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CFG_OFS  = 8'h00;
  localparam logic [7:0] CNT_OFS  = 8'h04;
  localparam logic [7:0] CTLB_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0c;
  localparam logic [7:0] TEST_OFS = 8'h10;

  // ==========================================================
  // configuration field positions
  localparam int RATE_LSB   = 0;
  localparam int RATE_W     = 3;
  localparam int ASSIGN_BIT = 3;
  localparam int EDGE_BIT   = 4;
  localparam int SRC_BIT    = 5;
  localparam int RIE_BIT    = 6;

  // ==========================================================
  // status field positions (timer1_control_b layout)
  localparam int PEND_BIT = 7;
  localparam int WDG_BIT  = 0;

  // ==========================================================
  // reset values and the rollover count value
  localparam logic [7:0] CFG_RST  = 8'h0f;
  localparam logic [7:0] CNT_RST  = 8'h00;
  localparam logic [7:0] CTLB_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] ROLL_VAL = 8'hff;

  // ==========================================================
  // prescaler terminal count: low rate+1 bits all ones
  function automatic logic presc_hit(input logic [7:0] cnt, input logic [2:0] rate);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m[i] = (i <= int'(rate));
    end
    return &(cnt | ~m);
  endfunction

endpackage

// *** hdl/tcp_prescaler.sv ***
// module: shared 8-bit prescaler with power-of-two terminal count
`timescale 1ns/100ps
`default_nettype none

module tcp_prescaler (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // link to control
  tcp_link_if.presc lk
);

  logic [7:0] count_q;

  // ==========================================================
  // count input ticks, clear wins over a tick
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= 8'h00;
    end else if (lk.clr) begin
      count_q <= 8'h00;
    end else if (lk.tick) begin
      count_q <= count_q + 8'h01;
    end
  end

  // pulse every 2^(rate+1) ticks, code 000 divides by two
  assign lk.pulse = lk.tick & ~lk.clr & tcp_pkg::presc_hit(count_q, lk.rate);

  a_presc_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    lk.clr |=> (count_q == 8'h00)) else $error("prescaler not cleared");
  a_presc_ratio: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (lk.tick && !lk.clr && lk.rate == 3'h0 && count_q[0]) |-> lk.pulse)
    else $error("divide by two missed");

endmodule

`default_nettype wire

// *** hdl/tcp_tick_counter.sv ***
// module: 8-bit tick counter with prescaler, watchdog postscaler and apb registers
// Notes on behaviour
// - an 8-bit counter advances once per instruction cycle or per selected pin transition.
// - with the source bit (bit 5) clear, increments come from the instruction cycle.
// - with the source bit set, the count pin is sampled each oscillator edge.
// - edge bit (bit 4) set counts falling edges, clear counts rising edges.
// - an 8-bit prescaler ahead of the counter extends the chain to 16 bits.
// - a prescaler not given to the counter serves as watchdog postscaler.
// - rollover from ff to 00 sets the pending bit 7 and may request an interrupt.
// - a counter write clears the prescaler only when the assign bit 3 is zero.
// - a zero-test read inhibits the increment, a plain read does not.
// - assign bit one gives the prescaler to the watchdog, zero to the counter, never both.
// - the rollover interrupt enable sits in the configuration register.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module tcp_tick_counter #(
  parameter int CYC_DIV = 1
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // apb slave
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // external count pin
  input  wire logic        count_pin_in,
  // watchdog counter
  input  wire logic        watchdog_tick_in,
  output logic             watchdog_timeout_out,
  // interrupt
  output logic             irq_out
);

  localparam int CW = (CYC_DIV > 1) ? $clog2(CYC_DIV) : 1;

  tcp_link_if lk ();

  logic [7:0]  cfg_q;
  logic [7:0]  cnt_q;
  logic [7:0]  ctlb_q;
  logic [7:0]  mask_q;
  logic [31:0] prdata_q;
  logic        irq_q;
  logic        wdg_out_q;
  logic        assign_q;
  logic [CW-1:0] cyc_q;
  logic        cyc_en;
  logic        setup;
  logic        access;
  logic        wr_en;
  logic        cnt_wr;
  logic        inhibit;
  logic        raw_tick;
  logic        cnt_inc;
  logic        to_wdg;

  // ==========================================================
  // address decode shared by write enable and error answer
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == tcp_pkg::CFG_OFS) || (a == tcp_pkg::CNT_OFS) || (a == tcp_pkg::CTLB_OFS) ||
           (a == tcp_pkg::MASK_OFS) || (a == tcp_pkg::TEST_OFS);
  endfunction

  // ==========================================================
  // apb phases, zero wait states
  assign setup       = psel_in & ~penable_in;
  assign access      = psel_in & penable_in;
  assign wr_en       = access & pwrite_in & addr_ok(paddr_in);
  assign cnt_wr      = wr_en & (paddr_in == tcp_pkg::CNT_OFS);
  assign pready_out  = 1'b1;
  assign pslverr_out = access & ~addr_ok(paddr_in);
  assign prdata_out  = prdata_q;

  // zero-test view holds the count for both phases of the read
  assign inhibit = psel_in & ~pwrite_in & (paddr_in == tcp_pkg::TEST_OFS);

  // read data captured at setup so the access edge takes a flopped value
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite_in) begin
      case (paddr_in)
        tcp_pkg::CFG_OFS:  prdata_q <= {24'h00_0000, cfg_q};
        tcp_pkg::CNT_OFS:  prdata_q <= {24'h00_0000, cnt_q};
        tcp_pkg::CTLB_OFS: prdata_q <= {24'h00_0000, ctlb_q};
        tcp_pkg::MASK_OFS: prdata_q <= {24'h00_0000, mask_q};
        tcp_pkg::TEST_OFS: prdata_q <= {24'h00_0000, cnt_q};
        default:           prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // configuration and mask registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_q  <= tcp_pkg::CFG_RST;
      mask_q <= tcp_pkg::MASK_RST;
    end else if (wr_en) begin
      if (paddr_in == tcp_pkg::CFG_OFS) begin
        cfg_q <= pwdata_in[7:0];
      end
      if (paddr_in == tcp_pkg::MASK_OFS) begin
        mask_q <= pwdata_in[7:0];
      end
    end
  end

  // ==========================================================
  // instruction cycle enable from a divider of the core clock
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cyc_q <= '0;
    end else if (cyc_en) begin
      cyc_q <= '0;
    end else begin
      cyc_q <= cyc_q + CW'(1);
    end
  end

  // terminal count of the cycle divider, one pulse per instruction cycle
  assign cyc_en = (cyc_q == CW'(CYC_DIV - 1));

  // ==========================================================
  // source and prescaler routing
  assign to_wdg      = cfg_q[tcp_pkg::ASSIGN_BIT];
  assign raw_tick    = cfg_q[tcp_pkg::SRC_BIT] ? lk.edge_seen : cyc_en;
  assign lk.pin      = count_pin_in;
  assign lk.fall_sel = cfg_q[tcp_pkg::EDGE_BIT];
  assign lk.rate     = cfg_q[tcp_pkg::RATE_LSB +: tcp_pkg::RATE_W];
  assign lk.tick     = to_wdg ? watchdog_tick_in : raw_tick;
  // reassignment also clears, so a stale partial count never leaks across owners
  assign lk.clr      = (cnt_wr & ~to_wdg) | (assign_q != to_wdg);
  assign cnt_inc     = (to_wdg ? raw_tick : lk.pulse) & ~inhibit;

  // owner seen last cycle; a change of owner restarts the prescaler
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      assign_q <= tcp_pkg::CFG_RST[tcp_pkg::ASSIGN_BIT];
    end else begin
      assign_q <= to_wdg;
    end
  end

  // ==========================================================
  // tick counter, a software write wins over an increment
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= tcp_pkg::CNT_RST;
    end else if (cnt_wr) begin
      cnt_q <= pwdata_in[7:0];
    end else if (cnt_inc) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // ==========================================================
  // sticky status, set wins over write-one-to-clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctlb_q <= tcp_pkg::CTLB_RST;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (wr_en && paddr_in == tcp_pkg::CTLB_OFS && pwdata_in[i]) begin
          ctlb_q[i] <= 1'b0;
        end
      end
      if (cnt_inc && !cnt_wr && cnt_q == tcp_pkg::ROLL_VAL) begin
        ctlb_q[tcp_pkg::PEND_BIT] <= 1'b1;
      end
      if (to_wdg && lk.pulse) begin
        ctlb_q[tcp_pkg::WDG_BIT] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // interrupt level and watchdog postscaled output
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_q     <= 1'b0;
      wdg_out_q <= 1'b0;
    end else begin
      irq_q <= (ctlb_q[tcp_pkg::PEND_BIT] & mask_q[tcp_pkg::PEND_BIT] &
                cfg_q[tcp_pkg::RIE_BIT]) |
               (ctlb_q[tcp_pkg::WDG_BIT] & mask_q[tcp_pkg::WDG_BIT]);
      wdg_out_q <= to_wdg ? lk.pulse : watchdog_tick_in;
    end
  end

  // outputs straight from flops, no glitches towards the core
  assign irq_out              = irq_q;
  assign watchdog_timeout_out = wdg_out_q;

  // ==========================================================
  // submodules
  tcp_prescaler u_presc (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .lk       (lk.presc)
  );

  tcp_pin_sampler u_smp (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .lk       (lk.smp)
  );

  // ==========================================================
  // checks
  a_rollover_pend: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cnt_inc && !cnt_wr && cnt_q == 8'hff) |=> (ctlb_q[7] && cnt_q == 8'h00))
    else $error("rollover did not set pending");
  a_internal_inc: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!cfg_q[5] && cfg_q[3] && cyc_en && !inhibit && !cnt_wr) |=>
    (cnt_q == 8'($past(cnt_q) + 8'h01))) else $error("instruction cycle not counted");
  a_external_inc: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cfg_q[5] && cfg_q[3] && lk.edge_seen && !inhibit && !cnt_wr) |=>
    (cnt_q == 8'($past(cnt_q) + 8'h01))) else $error("pin edge not counted");
  a_test_inhibit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (inhibit && !cnt_wr) |=> $stable(cnt_q)) else $error("zero-test let count advance");
  a_no_sharing: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_q[3] |-> (lk.tick == watchdog_tick_in && !(cnt_inc && !raw_tick)))
    else $error("prescaler shared");
  a_postscale_out: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cfg_q[3] && lk.pulse) |=> watchdog_timeout_out) else $error("postscaler pulse lost");
  a_irq_enable: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!cfg_q[6] && !(ctlb_q[0] && mask_q[0])) |=> !irq_out) else $error("irq while disabled");
  a_presc_chain: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!cfg_q[3] && !cnt_wr && !inhibit && !lk.pulse) |=> $stable(cnt_q))
    else $error("counter moved without prescaler pulse");

  // ==========================================================
  // checks on counter writes and the shared prescaler
  a_write_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cnt_wr && !cfg_q[3]) |=> (u_presc.count_q == 8'h00))
    else $error("counter write left prescaler count");
  a_write_keeps: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cnt_wr && cfg_q[3] && assign_q && !lk.tick) |=> $stable(u_presc.count_q))
    else $error("counter write disturbed postscaler");
  a_write_wins: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cnt_wr |=> ({24'h00_0000, cnt_q} == ($past(pwdata_in) & 32'h0000_00ff)))
    else $error("counter write lost");
  a_presc_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (lk.tick && !lk.clr) |=> (u_presc.count_q == 8'($past(u_presc.count_q) + 8'h01)))
    else $error("prescaler missed a tick");
  a_rate_max: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (lk.tick && lk.rate == 3'h7 && u_presc.count_q != 8'hff) |-> !lk.pulse)
    else $error("divide by 256 pulsed early");

  // ==========================================================
  // checks on pending flag and interrupt level
  a_pend_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ctlb_q[7] && !(wr_en && paddr_in == tcp_pkg::CTLB_OFS && pwdata_in[7])) |=> ctlb_q[7])
    else $error("pending flag dropped");
  a_pend_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_en && paddr_in == tcp_pkg::CTLB_OFS && pwdata_in[7] &&
     !(cnt_inc && cnt_q == 8'hff)) |=> !ctlb_q[7])
    else $error("pending flag not cleared");
  a_irq_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ctlb_q[7] && mask_q[7] && cfg_q[6]) |=> irq_out)
    else $error("enabled rollover gave no interrupt");

  // ==========================================================
  // checks on counting sources and the plain read
  a_presc_inc: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!cfg_q[5] && !cfg_q[3] && lk.pulse && !inhibit && !cnt_wr) |=>
    (cnt_q == 8'($past(cnt_q) + 8'h01))) else $error("prescaler pulse not counted");
  a_plain_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (psel_in && !pwrite_in && paddr_in == tcp_pkg::CNT_OFS && !cfg_q[5] && cfg_q[3] &&
     cyc_en) |=> (cnt_q == 8'($past(cnt_q) + 8'h01)))
    else $error("plain read stalled the count");
  a_edge_only: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cfg_q[5] && cfg_q[3] && !lk.edge_seen && !cnt_wr) |=> $stable(cnt_q))
    else $error("count moved without pin edge");

  // ==========================================================
  // checks on the chosen pin transition
  a_rise_select: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!cfg_q[4] && !u_smp.prev_q && count_pin_in) |=> lk.edge_seen)
    else $error("rising edge lost");
  a_fall_ignore: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cfg_q[4] && !u_smp.prev_q) |=> !lk.edge_seen)
    else $error("rising edge counted in falling mode");

  // ==========================================================
  // checks on watchdog routing
  a_wdg_copy: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !cfg_q[3] |=> (watchdog_timeout_out == $past(watchdog_tick_in)))
    else $error("watchdog tick not passed through");
  a_wdg_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cfg_q[3] && !lk.pulse) |=> !watchdog_timeout_out)
    else $error("postscaler output without pulse");

endmodule

`default_nettype wire

// *** sim/tcp_pin_source.sv ***
// partner model: external signal source driving the count pin
`timescale 1ns/100ps
`default_nettype none

module tcp_pin_source (
  // clock
  input  wire logic clk_in,
  // count pin
  output logic      pin_out
);
  // =====================
  // pin starts low, moves only after a clock edge
  initial pin_out = 1'b0;

  // toggle n times; each level held three clocks, so no edge is missed
  task automatic toggle(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      pin_out <= ~pin_out;
      repeat (2) @(posedge clk_in);
    end
  endtask
endmodule

`default_nettype wire

// *** sim/tcp_tick_counter_tb_top.sv ***
// testbench: apb driven checks of the tick counter block
`timescale 1ns/100ps
`default_nettype none

module tcp_tick_counter_tb_top;
  // =====================
  // bench signals
  logic        clk_in       = 1'b0;
  logic        rst_n_in     = 1'b0;
  logic [7:0]  paddr        = 8'h00;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic [31:0] pwdata       = 32'h0;
  logic        wd_tick      = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        wd_to;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  c0, c1, c2;
  int          miscompares  = 0;
  int          total_checks = 0;
  int          wd_seen      = 0;
  int          base;
  // rows: config byte, expected count after 3.5 prescaled periods
  logic [15:0] rows [8]     = '{16'h0003, 16'h0103, 16'h0203, 16'h0303,
                                16'h0403, 16'h0503, 16'h0603, 16'h0703};
  logic [7:0]  rst_v [4]    = '{tcp_pkg::CFG_RST, tcp_pkg::CNT_RST,
                                tcp_pkg::CTLB_RST, tcp_pkg::MASK_RST};

  // 25 MHz clock
  always #20 clk_in = ~clk_in;

  // =====================
  // design and partner
  tcp_tick_counter #(.CYC_DIV(1)) tcp_tick_counter_inst (
    .clk_in               (clk_in),
    .rst_n_in             (rst_n_in),
    .paddr_in             (paddr),
    .psel_in              (psel),
    .penable_in           (penable),
    .pwrite_in            (pwrite),
    .pwdata_in            (pwdata),
    .prdata_out           (prdata),
    .pready_out           (pready),
    .pslverr_out          (pslverr),
    .count_pin_in         (pin),
    .watchdog_tick_in     (wd_tick),
    .watchdog_timeout_out (wd_to),
    .irq_out              (irq)
  );
  tcp_pin_source tcp_pin_source_inst (
    .clk_in  (clk_in),
    .pin_out (pin)
  );

  // count watchdog output pulses
  always @(posedge clk_in) begin
    if (wd_to === 1'b1) wd_seen++;
  end

  // =====================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; holds everything until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk_in);
    penable <= 1'b1;
    // no wait limit here: only the hang guard ends a stuck transfer
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard, well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    end_of_test();
  end

  // =====================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    chk({30'h0, irq, wd_to}, 32'h0);
    rst_n_in <= 1'b1;
    // reset values; the count runs from release, so it is skipped
    for (int i = 0; i < 4; i++) begin
      if (i != 1) begin
        apb(1'b0, 8'(i * 4), 8'h00);
        chk(rd, {24'h0, rst_v[i]});
      end
    end
    // unmapped place is refused
    apb(1'b0, 8'h20, 8'h00);
    chk({rd[30:0], err}, 32'h1);
    // prescaled internal count for every rate code
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, tcp_pkg::CFG_OFS, rows[i][15:8]);
      apb(1'b1, tcp_pkg::CNT_OFS, 8'h00);
      repeat (3 * (2 << i) + (1 << i) - 2) @(posedge clk_in);
      apb(1'b0, tcp_pkg::CNT_OFS, 8'h00);
      chk(rd, {24'h0, rows[i][7:0]});
    end
    // pin source: five toggles give three of the chosen edge
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, tcp_pkg::CFG_OFS, 8'h28 | 8'(e << 4));
      apb(1'b1, tcp_pkg::CNT_OFS, 8'h00);
      tcp_pin_source_inst.toggle(5);
      repeat (4) @(posedge clk_in);
      apb(1'b0, tcp_pkg::CNT_OFS, 8'h00);
      chk(rd, 32'h3);
    end
    // watchdog ticks: copied, then halved by the postscaler
    for (int a = 0; a < 2; a++) begin
      apb(1'b1, tcp_pkg::CFG_OFS, (a == 1) ? 8'h08 : 8'h00);
      base = wd_seen;
      repeat (4) begin
        @(posedge clk_in);
        wd_tick <= 1'b1;
        @(posedge clk_in);
        wd_tick <= 1'b0;
        repeat (2) @(posedge clk_in);
      end
      repeat (3) @(posedge clk_in);
      chk(32'(wd_seen - base), (a == 1) ? 32'h2 : 32'h4);
    end
    // zero-test view stalls the count for its two bus cycles
    apb(1'b0, tcp_pkg::CNT_OFS, 8'h00);
    c0 = rd[7:0];
    apb(1'b0, tcp_pkg::CNT_OFS, 8'h00);
    c1 = rd[7:0];
    chk({24'h0, 8'(c1 - c0)}, 32'h3);
    apb(1'b0, tcp_pkg::TEST_OFS, 8'h00);
    chk(rd, {24'h0, 8'(c1 + 8'h03)});
    apb(1'b0, tcp_pkg::CNT_OFS, 8'h00);
    c2 = rd[7:0];
    chk({24'h0, 8'(c2 - c1)}, {24'h0, 8'(2 * (c1 - c0) - 2)});
    // rollover: pending, interrupt, clear, mask, enable
    apb(1'b1, tcp_pkg::CFG_OFS, 8'h48);
    apb(1'b1, tcp_pkg::MASK_OFS, 8'h80);
    apb(1'b1, tcp_pkg::CNT_OFS, 8'hfe);
    repeat (4) @(posedge clk_in);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, tcp_pkg::CTLB_OFS, 8'h00);
    chk(rd & 32'h80, 32'h80);
    apb(1'b1, tcp_pkg::CTLB_OFS, 8'h80);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, tcp_pkg::MASK_OFS, 8'h00);
    repeat (300) @(posedge clk_in);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, tcp_pkg::CTLB_OFS, 8'h00);
    chk(rd & 32'h80, 32'h80);
    apb(1'b1, tcp_pkg::MASK_OFS, 8'h80);
    apb(1'b1, tcp_pkg::CFG_OFS, 8'h08);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq}, 32'h0);
    // mid-run reset: outputs quiet, registers other than the count back to reset values
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk({30'h0, irq, wd_to}, 32'h0);
    rst_n_in <= 1'b1;
    apb(1'b0, tcp_pkg::CFG_OFS, 8'h00);
    chk(rd, {24'h0, tcp_pkg::CFG_RST});
    apb(1'b0, tcp_pkg::CTLB_OFS, 8'h00);
    chk(rd, {24'h0, tcp_pkg::CTLB_RST});
    apb(1'b0, tcp_pkg::MASK_OFS, 8'h00);
    chk(rd, {24'h0, tcp_pkg::MASK_RST});
    end_of_test();
  end
endmodule

`default_nettype wire
